// file: rtl/ccr_pkg.sv
// register map, field layout, reset values and decode constants of the charger control bank
// assumes a single 250 MHz clock domain shared with the serial register interface
`default_nettype none

package ccr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] CCR_OFS_CURRENT = 8'h04; // precharge / termination current
  localparam logic [7:0] CCR_OFS_TIMERS  = 8'h05; // timers and termination
  localparam logic [7:0] CCR_OFS_ENABLES = 8'h06; // enables and thresholds

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CCR_RST_CURRENT = 8'h22;
  localparam logic [7:0] CCR_RST_TIMERS  = 8'h9d;
  localparam logic [7:0] CCR_RST_ENABLES = 8'h7d;
  localparam logic [7:0] CCR_RDATA_NONE  = 8'h00; // answer of an unmapped read

  // ****************************************
  // field positions
  // ****************************************
  localparam int CCR_TERM_EN_BIT   = 7;
  localparam int CCR_RSVD_BIT      = 6;
  localparam int CCR_WDOG_LSB      = 4;
  localparam int CCR_TIMER_EN_BIT  = 3;
  localparam int CCR_DUR_LSB       = 1;
  localparam int CCR_HALF_RATE_BIT = 0;
  localparam int CCR_BUCK_EN_BIT   = 7;
  localparam int CCR_AUTO_DET_BIT  = 6;
  localparam int CCR_THERM_LSB     = 4;
  localparam int CCR_CHG_EN_BIT    = 3;
  localparam int CCR_ENTRY_BIT     = 2;
  localparam int CCR_RECHG_LSB     = 0;
  localparam logic [7:0] CCR_KEEP_ON_WDOG = 8'h03; // recharge offset survives expiry

  // ****************************************
  // decode constants
  // ****************************************
  localparam logic [10:0] CCR_CUR_STEP_MA   = 11'h032; // 50 mA per step and offset
  localparam logic [8:0]  CCR_RECHG_STEP_MV = 9'h064;  // 100 mV per step and offset
  localparam logic [6:0]  CCR_THERM_BASE_C  = 7'h3c;   // 60 C
  localparam logic [6:0]  CCR_THERM_STEP_C  = 7'h14;   // 20 C
  localparam logic [12:0] CCR_ENTRY_LOW_MV  = 13'h15e0; // 5.6 V
  localparam logic [12:0] CCR_ENTRY_HIGH_MV = 13'h1770; // 6.0 V
  localparam logic [7:0]  CCR_WDOG_S40      = 8'h28;
  localparam logic [7:0]  CCR_WDOG_S80      = 8'h50;
  localparam logic [7:0]  CCR_WDOG_S160     = 8'ha0;
  localparam logic [4:0]  CCR_DUR_H5        = 5'h05;
  localparam logic [4:0]  CCR_DUR_H8        = 5'h08;
  localparam logic [4:0]  CCR_DUR_H12       = 5'h0c;
  localparam logic [4:0]  CCR_DUR_H20       = 5'h14;

  // whole state of the bank
  typedef struct packed {
    logic [7:0] r04;        // current codes
    logic [7:0] r05;        // timer settings, reserved bit kept zero
    logic [7:0] r06;        // enables and thresholds
    logic [7:0] rdata;      // read answer
    logic       wd_restart; // watchdog counter restart pulse
    logic       st_restart; // safety timer restart pulse
    logic       det_start;  // source detection start pulse
    logic [2:0] sync1;      // first synchroniser stage
    logic [2:0] sync2;      // second synchroniser stage
    logic       vbus_prev;  // vbus level one cycle ago
  } ccr_state_type;

endpackage : ccr_pkg

`default_nettype wire

// file: rtl/ccr_regs.sv
// charger control register bank: three configuration bytes and their decoded settings
// assumes the serial slave delivers byte writes and reads as one-cycle strobes on mclk;
// the analog status levels arrive from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic        mclk,                  // 250 MHz clock
  input  wire logic        reset_n,               // synchronous reset
  input  wire logic        reg_reset,             // register reset pulse
  input  wire logic        watchdog_expired,      // watchdog expiry pulse
  input  wire logic        watchdog_restart_bit,  // host wrote the restart bit
  input  wire logic        wr_en,                 // byte write strobe
  input  wire logic        rd_en,                 // byte read strobe
  input  wire logic [7:0]  addr,                  // register offset
  input  wire logic [7:0]  wdata,                 // write byte
  output logic      [7:0]  rdata,                 // read byte, one cycle after rd_en
  input  wire logic        input_reg_active,      // input regulation, async level
  input  wire logic        thermal_reg_active,    // thermal regulation, async level
  input  wire logic        vbus_present,          // vbus level, async
  output logic      [10:0] precharge_current_ma,  // precharge current
  output logic      [10:0] termination_current_ma,// termination current
  output logic             termination_enable,    // charge termination on
  output logic      [7:0]  watchdog_period_s,     // 0 means disabled
  output logic             watchdog_counter_restart, // restart pulse
  output logic             safety_timer_enable,   // safety timer on
  output logic      [4:0]  safety_timer_hours,    // fast charge limit
  output logic             safety_timer_restart,  // restart pulse
  output logic             safety_timer_slow,     // count at half rate
  output logic             charge_enable,         // charging on
  output logic             buck_output_active,    // otg buck on
  output logic             source_detect_start,   // detection start pulse
  output logic      [6:0]  thermal_threshold_c,   // regulation threshold
  output logic      [12:0] fast_charge_entry_mv,  // precharge exit voltage
  output logic      [8:0]  recharge_offset_mv     // below regulation voltage
);

  ccr_state_type st_q; // registered state
  ccr_state_type st_d; // next state
  logic          wr04; // write hits each register
  logic          wr05;
  logic          wr06;
  logic          rst_any;

  assign wr04    = wr_en && (addr == CCR_OFS_CURRENT);
  assign wr05    = wr_en && (addr == CCR_OFS_TIMERS);
  assign wr06    = wr_en && (addr == CCR_OFS_ENABLES);
  assign rst_any = reg_reset || watchdog_expired;

  // ****************************************
  // next state
  // ****************************************
  // resets win over a write in the same cycle, the host must rewrite afterwards
  always_comb
  begin
    st_d            = st_q;
    st_d.wd_restart = 1'b0;
    st_d.st_restart = 1'b0;
    st_d.det_start  = 1'b0;
    // two flop synchroniser, first stage read only by the second
    st_d.sync1      = {vbus_present, thermal_reg_active, input_reg_active};
    st_d.sync2      = st_q.sync1;
    st_d.vbus_prev  = st_q.sync2[2];
    if (!reset_n)
    begin
      st_d = '0;
      st_d.r04 = CCR_RST_CURRENT;
      st_d.r05 = CCR_RST_TIMERS;
      st_d.r06 = CCR_RST_ENABLES;
    end
    else
    begin
      if (rst_any)
      begin
        st_d.r04 = CCR_RST_CURRENT;
        st_d.r05 = CCR_RST_TIMERS;
        st_d.r06 = reg_reset ? CCR_RST_ENABLES :
                   ((CCR_RST_ENABLES & ~CCR_KEEP_ON_WDOG) | (st_q.r06 & CCR_KEEP_ON_WDOG));
      end
      else
      begin
        if (wr04)
          st_d.r04 = wdata;
        if (wr06)
          st_d.r06 = wdata;
        if (wr05)
        begin
          st_d.r05 = wdata & ~(8'h01 << CCR_RSVD_BIT);
          if (wdata[CCR_WDOG_LSB +: 2] != st_q.r05[CCR_WDOG_LSB +: 2])
            st_d.wd_restart = 1'b1;
          if (wdata[CCR_DUR_LSB +: 2] != st_q.r05[CCR_DUR_LSB +: 2])
            st_d.st_restart = 1'b1;
        end
      end
      if (watchdog_restart_bit)
        st_d.wd_restart = 1'b1;
      if (st_q.sync2[2] && !st_q.vbus_prev && st_q.r06[CCR_AUTO_DET_BIT])
        st_d.det_start = 1'b1;
      if (rd_en)
      begin
        case (addr)
          CCR_OFS_CURRENT: st_d.rdata = st_q.r04;
          CCR_OFS_TIMERS:  st_d.rdata = st_q.r05;
          CCR_OFS_ENABLES: st_d.rdata = st_q.r06;
          default:         st_d.rdata = CCR_RDATA_NONE;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    st_q <= st_d;
  end

  // ****************************************
  // field decode
  // ****************************************
  // code times step plus one step
  assign precharge_current_ma   = 11'(st_q.r04[7:4]) * CCR_CUR_STEP_MA + CCR_CUR_STEP_MA;
  assign termination_current_ma = 11'(st_q.r04[3:0]) * CCR_CUR_STEP_MA + CCR_CUR_STEP_MA;
  assign termination_enable     = st_q.r05[CCR_TERM_EN_BIT];
  assign safety_timer_enable    = st_q.r05[CCR_TIMER_EN_BIT];
  // slow only while a loop regulates
  assign safety_timer_slow      = st_q.r05[CCR_HALF_RATE_BIT] && (st_q.sync2[0] || st_q.sync2[1]);
  assign charge_enable          = st_q.r06[CCR_CHG_EN_BIT];
  assign buck_output_active     = st_q.r06[CCR_BUCK_EN_BIT] && !st_q.r06[CCR_CHG_EN_BIT];
  assign thermal_threshold_c    = CCR_THERM_BASE_C + 7'(st_q.r06[CCR_THERM_LSB +: 2]) * CCR_THERM_STEP_C;
  assign fast_charge_entry_mv   = st_q.r06[CCR_ENTRY_BIT] ? CCR_ENTRY_HIGH_MV : CCR_ENTRY_LOW_MV;
  assign recharge_offset_mv     = 9'(st_q.r06[CCR_RECHG_LSB +: 2]) * CCR_RECHG_STEP_MV + CCR_RECHG_STEP_MV;
  assign rdata                    = st_q.rdata;
  assign watchdog_counter_restart = st_q.wd_restart;
  assign safety_timer_restart     = st_q.st_restart;
  assign source_detect_start      = st_q.det_start;

  // period and duration lookups
  always_comb
  begin
    case (st_q.r05[CCR_WDOG_LSB +: 2])
      2'h0:    watchdog_period_s = 8'h00;
      2'h1:    watchdog_period_s = CCR_WDOG_S40;
      2'h2:    watchdog_period_s = CCR_WDOG_S80;
      default: watchdog_period_s = CCR_WDOG_S160;
    endcase
    case (st_q.r05[CCR_DUR_LSB +: 2])
      2'h0:    safety_timer_hours = CCR_DUR_H5;
      2'h1:    safety_timer_hours = CCR_DUR_H8;
      2'h2:    safety_timer_hours = CCR_DUR_H12;
      default: safety_timer_hours = CCR_DUR_H20;
    endcase
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  rsvd_reads_zero_a: assert property (
    rd_en && addr == CCR_OFS_TIMERS |=> rdata[CCR_RSVD_BIT] == 1'b0)
    else $error("reserved bit read as one");
  wdog_change_restart_a: assert property (
    wr05 && !rst_any && wdata[5:4] != st_q.r05[5:4] |=> watchdog_counter_restart)
    else $error("watchdog not restarted on period change");
  wdog_same_hold_a: assert property (
    wr05 && !watchdog_restart_bit && wdata[5:4] == st_q.r05[5:4] |=> !watchdog_counter_restart)
    else $error("watchdog restarted on same period");
  timer_change_restart_a: assert property (
    wr05 && !rst_any && wdata[2:1] != st_q.r05[2:1] |=> safety_timer_restart)
    else $error("safety timer not restarted on duration change");
  timer_same_hold_a: assert property (
    wr05 && wdata[2:1] == st_q.r05[2:1] |=> !safety_timer_restart)
    else $error("safety timer restarted on same duration");
  buck_priority_a: assert property (
    charge_enable |-> !buck_output_active)
    else $error("buck active while charging");
  expiry_keeps_rechg_a: assert property (
    watchdog_expired && !reg_reset |=> recharge_offset_mv == $past(recharge_offset_mv))
    else $error("recharge offset lost on expiry");
  expiry_defaults_a: assert property (
    watchdog_expired |=> st_q.r04 == CCR_RST_CURRENT && st_q.r05 == CCR_RST_TIMERS)
    else $error("expiry did not restore defaults");
  // write, one quiet cycle, then a read of the same byte, as the host model issues them
  write_readback_a: assert property (
    wr04 && !rst_any ##1 !wr04 && !rst_any ##1 rd_en && addr == CCR_OFS_CURRENT
      |=> rdata == $past(wdata, 3))
    else $error("readback differs from written byte");
  kick_restart_a: assert property (
    watchdog_restart_bit |=> watchdog_counter_restart)
    else $error("restart bit did not restart watchdog");

  cov_period_change_c: cover property (wr05 ##1 watchdog_counter_restart);
  cov_expiry_c:        cover property (watchdog_expired && st_q.r06[1:0] != CCR_RST_ENABLES[1:0]);
  cov_detect_c:        cover property (source_detect_start);

endmodule : ccr_regs

`default_nettype wire

// file: sim/ccr_host.sv
// host model of the charger control bank: byte writes, byte reads and watchdog kicks
// assumes one mclk domain; requests launch at a rising edge and hold one cycle
`timescale 1ns/1ps
`default_nettype none

module ccr_host (
  input  wire logic       mclk,                 // bank clock
  input  wire logic [7:0] rdata,                // read answer
  output logic            wr_en,                // write strobe
  output logic            rd_en,                // read strobe
  output logic      [7:0] addr,                 // register offset
  output logic      [7:0] wdata,                // write byte
  output logic            watchdog_restart_bit  // kick strobe
);
  // idle bus; released lines show the inverse of the last value
  initial
  begin
    {wr_en, rd_en, watchdog_restart_bit} = 3'h0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : wr

  // answer read one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    addr  <= ~a;
    #1;
    q = rdata;
  endtask : rd

  task automatic kick;
    @(posedge mclk);
    watchdog_restart_bit <= 1'b1;
    @(posedge mclk);
    watchdog_restart_bit <= 1'b0;
  endtask : kick
endmodule : ccr_host
`default_nettype wire

// file: sim/charger_control_regs_04_06_bench.sv
// bench of the charger control bank, compared with an integer model after every write
// assumes the host model drives the strobes; levels and pulses are driven from here
`timescale 1ns/1ps
`default_nettype none

module charger_control_regs_04_06_bench;
  logic        mclk = 1'b0, reset_n, reg_reset, watchdog_expired, vbus_present;
  logic        input_reg_active, thermal_reg_active, wr_en, rd_en, watchdog_restart_bit;
  logic        term_en, wd_rs, st_en, st_rs, st_slow, chg_en, buck_on, det_start;
  logic [7:0]  addr, wdata, rdata, wd_s;
  logic [10:0] pc_ma, tc_ma;
  logic [4:0]  st_h;
  logic [6:0]  th_c;
  logic [12:0] entry_mv;
  logic [8:0]  rech_mv;
  int          n_fail = 0, check_count = 0, n_wd = 0, n_st = 0, n_det = 0, d0;
  int          r4 = 'h22, r5 = 'h9d, r6 = 'h7d;  // model registers
  int          wd_t[4] = '{0, 40, 80, 160};
  int          hr_t[4] = '{5, 8, 12, 20};

  always #2 mclk = ~mclk;

  ccr_regs ccr_regs_inst (.mclk(mclk), .reset_n(reset_n), .reg_reset(reg_reset),
    .watchdog_expired(watchdog_expired), .watchdog_restart_bit(watchdog_restart_bit),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
    .input_reg_active(input_reg_active), .thermal_reg_active(thermal_reg_active),
    .vbus_present(vbus_present), .precharge_current_ma(pc_ma),
    .termination_current_ma(tc_ma), .termination_enable(term_en),
    .watchdog_period_s(wd_s), .watchdog_counter_restart(wd_rs),
    .safety_timer_enable(st_en), .safety_timer_hours(st_h), .safety_timer_restart(st_rs),
    .safety_timer_slow(st_slow), .charge_enable(chg_en), .buck_output_active(buck_on),
    .source_detect_start(det_start), .thermal_threshold_c(th_c),
    .fast_charge_entry_mv(entry_mv), .recharge_offset_mv(rech_mv));

  ccr_host ccr_host_inst (.mclk(mclk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .watchdog_restart_bit(watchdog_restart_bit));

  // pulse counters; a one-cycle pulse adds exactly one
  always @(posedge mclk)
  begin
    n_wd  += int'(wd_rs === 1'b1);
    n_st  += int'(st_rs === 1'b1);
    n_det += int'(det_start === 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // every decoded setting except safety_timer_slow against the model
  task automatic check_all;
    chk(32'(pc_ma), 32'((r4 / 16 + 1) * 50));
    chk(32'(tc_ma), 32'((r4 % 16 + 1) * 50));
    chk(32'(term_en), 32'(r5 / 128));
    chk(32'(wd_s), 32'(wd_t[(r5 / 16) % 4]));
    chk(32'(st_en), 32'((r5 / 8) % 2));
    chk(32'(st_h), 32'(hr_t[(r5 / 2) % 4]));
    chk(32'(chg_en), 32'((r6 / 8) % 2));
    chk(32'(buck_on), 32'(r6 / 128 * (1 - (r6 / 8) % 2)));
    chk(32'(th_c), 32'(60 + 20 * ((r6 / 16) % 4)));
    chk(32'(entry_mv), 32'((r6 / 4) % 2 ? 6000 : 5600));
    chk(32'(rech_mv), 32'((r6 % 4 + 1) * 100));
  endtask : check_all

  task automatic rb(input int a);
    logic [7:0] v;
    ccr_host_inst.rd(8'(a), v);
    chk(32'(v), 32'(a == 4 ? r4 : a == 5 ? r5 : a == 6 ? r6 : 0));
  endtask : rb

  // write, read straight back, then restart pulses and decodes;
  // the read follows the write after one quiet cycle, so the pulse is counted by then
  task automatic wchk(input int a, input int d);
    int w0, s0, ew, es;
    w0 = n_wd;
    s0 = n_st;
    ew = int'(a == 5 && ((d ^ r5) & 'h30) != 0);
    es = int'(a == 5 && ((d ^ r5) & 'h06) != 0);
    ccr_host_inst.wr(8'(a), 8'(d));
    if (a == 4)
      r4 = d;
    if (a == 5)
      r5 = d & 'hbf;
    if (a == 6)
      r6 = d;
    rb(a);
    chk(32'(n_wd - w0), 32'(ew));
    chk(32'(n_st - s0), 32'(es));
    check_all;
  endtask : wchk

  // one-cycle expiry (0) or register reset (1)
  task automatic pulse(input int which);
    @(posedge mclk);
    if (which == 0)
      watchdog_expired <= 1'b1;
    else
      reg_reset <= 1'b1;
    @(posedge mclk);
    watchdog_expired <= 1'b0;
    reg_reset        <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : pulse

  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // main sequence: defaults, every two-bit field code, random bytes, levels, resets, kick
  initial
  begin
    {reset_n, reg_reset, watchdog_expired, vbus_present} = 4'h0;
    {input_reg_active, thermal_reg_active} = 2'h0;
    void'($urandom(86));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    check_all;
    for (int a = 3; a < 8; a++)
      rb(a);
    for (int i = 0; i < 4; i++)
    begin
      wchk(5, 'h40 | i * 'h12 | (i % 2) * 'h88);
      wchk(6, i * 'h51 | (i / 3) * 'h0c);
      wchk(5, r5);
    end
    for (int n = 0; n < 40; n++)
      wchk(int'(3 + $urandom % 5), int'($urandom % 256));
    for (int k = 0; k < 8; k++)
    begin
      @(posedge mclk);
      input_reg_active   <= k[0];
      thermal_reg_active <= k[1];
      wchk(5, r5 / 2 * 2 + k / 4);
      chk(32'(st_slow), 32'(k / 4 * int'(k % 4 != 0)));
    end
    for (int b = 0; b < 2; b++)
    begin
      wchk(6, r6 & 'hbf | b * 'h40);
      @(posedge mclk);
      vbus_present <= 1'b1;
      d0 = n_det;
      repeat (6) @(posedge mclk);
      #1;
      chk(32'(n_det - d0), 32'(b));
      @(posedge mclk);
      vbus_present <= 1'b0;
    end
    wchk(4, 'hff);
    wchk(5, 'h6e);
    wchk(6, 'h82);
    pulse(0);
    r4 = 'h22;
    r5 = 'h9d;
    r6 = 'h7c | r6 & 3;
    check_all;
    rb(6);
    wchk(4, 'h5a);
    wchk(5, 'h21);
    wchk(6, 'h83);
    pulse(1);
    r4 = 'h22;
    r5 = 'h9d;
    r6 = 'h7d;
    check_all;
    rb(6);
    rb(5);
    d0 = n_wd;
    ccr_host_inst.kick;
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(n_wd - d0), 32'd1);
    report_and_stop;
  end

  // hang guard, far beyond the expected run
  initial
  begin
    #200000;
    n_fail++;
    report_and_stop;
  end
endmodule : charger_control_regs_04_06_bench
`default_nettype wire
